// [src/mcdt_core.v]
// Operation
// - All delay timing uses an 8-bit step timer shiftable left or right.
// - Preloaded values apply at commutation, or on phase write in direct mode.
// - 8x8 multiplier, two cascaded zero-cross captures, demag and compare registers.
// - Autoswitched mode commutes from rotor position and registers automatically.
// - Soft commutation compares written compare value to timer, event on match.
// - With soft commutation, no compare until compare register is written.
// - Nonzero speed sensor select gives speed measure only, no six-step.
// - Switched mode: timer reaching compare value commutes and resets timer.
// - Commutation loads preloads, sets commutation flag, irq only when masked in.
// - Ratio request shifts prescaler and timer registers at next commutation.
// - Ratio request bits clear in hardware once applied.
// - Writing both ratio request bits together is ignored.
// - Switched mode: zero-cross and demag events leave the timer alone.
// - Switched overflow restarts at zero; overflow flag only when select is 00.
// - Automatic ratio updating only in autoswitched mode (autoswitch select 1).
// - Timer clock stopped while enable is 0; divider writable directly.
// - Autoswitched compare equals weight times chosen zero-cross time over 256, or the timer value when that is not above it.
// - Autoswitched at 100h: prescaler up, registers halved, resume from 80h.
// - Autoswitched zero-cross below 55h: prescaler down, registers doubled.
`timescale 1ns/10ps
`include "mcdt_defs.vh"
module mcdt_core (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire zero_cross_in,
    input wire demag_in,
    output reg commutation_pulse,
    output reg irq_req,
    output reg [7:0] phase_state_out,
    output reg six_step_ok
);
    reg [3:0] control_a_reg;
    reg [1:0] control_c_reg;
    reg [3:0] prescaler_reg;
    reg [2:0] irq_status_reg;
    reg [1:0] irq_mask_reg;
    reg [1:0] speed_sensor_select;
    reg [7:0] step_timer;
    reg [7:0] commutation_compare;
    reg [7:0] zero_cross_latest;
    reg [7:0] zero_cross_prev;
    reg [7:0] demag_capture_reg;
    reg [7:0] delay_weight;
    reg [7:0] phase_state_reg;
    reg [7:0] phase_pre_r;
    reg compare_armed_r;
    reg [14:0] div_cnt_r;
    reg [1:0] zc_sync_r;
    reg [1:0] dm_sync_r;
    reg zc_prev_r;
    reg dm_prev_r;
    reg calc_pend_r;
    wire cke = control_a_reg[`MCDT_CA_CKE];
    wire auto_mode = control_a_reg[`MCDT_CA_SWA] & (speed_sensor_select == 2'b00);
    wire soft_c = control_c_reg[`MCDT_CC_SC];
    wire wr = psel & penable & pwrite;
    // One strobe per writable register keeps every write address compare in a single place
    wire wr_ctrl_a = wr & (paddr == `MCDT_A_CTRL_A);
    wire wr_ctrl_c = wr & (paddr == `MCDT_A_CTRL_C);
    wire wr_presc = wr & (paddr == `MCDT_A_PRESC);
    wire wr_irqst = wr & (paddr == `MCDT_A_IRQST);
    wire wr_irqmsk = wr & (paddr == `MCDT_A_IRQMSK);
    wire wr_sensor = wr & (paddr == `MCDT_A_SENSOR);
    wire wr_comp = wr & (paddr == `MCDT_A_COMP);
    wire wr_zlat = wr & (paddr == `MCDT_A_ZLAT);
    wire wr_demag = wr & (paddr == `MCDT_A_DEMAG);
    wire wr_weight = wr & (paddr == `MCDT_A_WEIGHT);
    wire wr_phase = wr & (paddr == `MCDT_A_PHASE);
    wire rd = psel & ~penable & ~pwrite;
    wire addr_bad = (paddr > `MCDT_A_PHASE) | (paddr[1:0] != 2'b00);
    wire [14:0] div_end = (15'h0001 << prescaler_reg) - 15'h0001;
    wire tick = cke & (div_cnt_r == div_end);
    wire pre_top = (prescaler_reg == `MCDT_PRE_MAX);
    wire pre_bot = (prescaler_reg == 4'h0);
    wire zc_ev = zc_sync_r[1] & ~zc_prev_r;
    wire dm_ev = dm_sync_r[1] & ~dm_prev_r;
    wire [7:0] mul_src = control_a_reg[`MCDT_CA_DCB] ? zero_cross_latest : zero_cross_prev;
    // Shift-and-add multiplier, one partial product row per weight bit
    wire [15:0] pp_sum [0:8];
    assign pp_sum[0] = 16'h0000;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_mul
            wire [15:0] row = delay_weight[gi] ? ({8'h00, mul_src} << gi) : 16'h0000;
            assign pp_sum[gi + 1] = pp_sum[gi] + row;
        end
    endgenerate
    wire [15:0] product = pp_sum[8];
    wire [7:0] mul_res = product[15:8];
    wire cmp_hit = compare_armed_r & (step_timer >= commutation_compare);
    wire comm_ev = cke & cmp_hit & (~auto_mode | soft_c | ~calc_pend_r);
    wire tmr_full = tick & (step_timer == 8'hff);
    wire up_auto = auto_mode & tmr_full & ~pre_top;
    wire dn_auto = auto_mode & zc_ev & (step_timer < `MCDT_T_LOW) & ~pre_bot;
    wire up_sw = ~auto_mode & comm_ev & irq_status_reg[`MCDT_IS_RPI] & ~pre_top;
    wire dn_sw = ~auto_mode & comm_ev & irq_status_reg[`MCDT_IS_RMI] & ~pre_bot;
    wire shr = up_auto | up_sw;
    wire shl = dn_auto | dn_sw;
    wire [1:0] req_wr = pwdata[`MCDT_IS_RMI:`MCDT_IS_RPI];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zc_sync_r <= 2'b00;
            dm_sync_r <= 2'b00;
            zc_prev_r <= 1'b0;
            dm_prev_r <= 1'b0;
        end else begin
            zc_sync_r <= {zc_sync_r[0], zero_cross_in};
            dm_sync_r <= {dm_sync_r[0], demag_in};
            zc_prev_r <= zc_sync_r[1];
            dm_prev_r <= dm_sync_r[1];
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 15'h0000;
        end else if (!cke || tick || shr || shl) begin
            div_cnt_r <= 15'h0000;
        end else begin
            div_cnt_r <= div_cnt_r + 15'h0001;
        end
    end
    // Timer and related registers shift together so stored times keep meaning after a ratio change
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_timer <= 8'h00;
            commutation_compare <= 8'h00;
            zero_cross_latest <= 8'h00;
            zero_cross_prev <= 8'h00;
            demag_capture_reg <= 8'h00;
            compare_armed_r <= 1'b0;
            calc_pend_r <= 1'b0;
            prescaler_reg <= `MCDT_PRE_RST;
        end else begin
            if (wr_presc && !cke) begin
                prescaler_reg <= pwdata[3:0];
            end else if (shr) begin
                prescaler_reg <= prescaler_reg + 4'h1;
            end else if (shl) begin
                prescaler_reg <= prescaler_reg - 4'h1;
            end
            if (shr) begin
                step_timer <= up_auto ? `MCDT_T_HALF : {1'b0, step_timer[7:1]};
                commutation_compare <= {1'b0, commutation_compare[7:1]};
                zero_cross_latest <= {1'b0, zero_cross_latest[7:1]};
                zero_cross_prev <= {1'b0, zero_cross_prev[7:1]};
                demag_capture_reg <= {1'b0, demag_capture_reg[7:1]};
                calc_pend_r <= auto_mode & ~soft_c;
                // A switched commutation still restarts the timer and disarms while the ratio moves
                if (comm_ev && !auto_mode) begin
                    step_timer <= 8'h00;
                    compare_armed_r <= 1'b0;
                end
            end else if (shl) begin
                step_timer <= dn_auto ? 8'h00 : {step_timer[6:0], 1'b0};
                commutation_compare <= {commutation_compare[6:0], 1'b0};
                zero_cross_latest <= dn_auto ? {step_timer[6:0], 1'b0} : {zero_cross_latest[6:0], 1'b0};
                zero_cross_prev <= dn_auto ? {zero_cross_latest[6:0], 1'b0} : {zero_cross_prev[6:0], 1'b0};
                demag_capture_reg <= {demag_capture_reg[6:0], 1'b0};
                calc_pend_r <= auto_mode & ~soft_c;
                if (dn_auto) begin
                    compare_armed_r <= 1'b0;
                end
                if (comm_ev && !auto_mode) begin
                    step_timer <= 8'h00;
                    compare_armed_r <= 1'b0;
                end
            end else begin
                if (comm_ev && !auto_mode) begin
                    step_timer <= 8'h00;
                end else if (auto_mode && zc_ev) begin
                    step_timer <= 8'h00;
                end else if (tick) begin
                    step_timer <= step_timer + 8'h01;
                end
                if (auto_mode && zc_ev) begin
                    zero_cross_prev <= zero_cross_latest;
                    zero_cross_latest <= step_timer;
                    calc_pend_r <= ~soft_c;
                    compare_armed_r <= soft_c ? 1'b0 : compare_armed_r;
                end else if (wr_zlat && auto_mode) begin
                    zero_cross_prev <= zero_cross_latest;
                    zero_cross_latest <= pwdata[7:0];
                end
                if (auto_mode && dm_ev) begin
                    demag_capture_reg <= step_timer;
                end else if (wr_demag) begin
                    demag_capture_reg <= pwdata[7:0];
                end
                if (wr_comp && (soft_c || !auto_mode)) begin
                    commutation_compare <= pwdata[7:0];
                    compare_armed_r <= 1'b1;
                end else if (calc_pend_r && auto_mode && !soft_c) begin
                    commutation_compare <= (mul_res <= step_timer) ? step_timer : mul_res;
                    compare_armed_r <= 1'b1;
                    calc_pend_r <= 1'b0;
                end else if (comm_ev) begin
                    compare_armed_r <= 1'b0;
                end
            end
        end
    end
    // Set wins over a software clear on the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 3'b000;
        end else begin
            if (wr_irqst) begin
                irq_status_reg[`MCDT_IS_CI] <= pwdata[`MCDT_IS_CI];
                if (req_wr != 2'b11) begin
                    irq_status_reg[`MCDT_IS_RMI:`MCDT_IS_RPI] <= req_wr;
                end
            end
            if (comm_ev) begin
                irq_status_reg[`MCDT_IS_CI] <= 1'b1;
            end
            if (up_sw || (comm_ev && !auto_mode && irq_status_reg[`MCDT_IS_RPI])) begin
                irq_status_reg[`MCDT_IS_RPI] <= 1'b0;
            end
            if (dn_sw || (comm_ev && !auto_mode && irq_status_reg[`MCDT_IS_RMI])) begin
                irq_status_reg[`MCDT_IS_RMI] <= 1'b0;
            end
            if (up_auto) begin
                irq_status_reg[`MCDT_IS_RPI] <= 1'b1;
            end
            if (dn_auto) begin
                irq_status_reg[`MCDT_IS_RMI] <= 1'b1;
            end
        end
    end
    // Overflow set wins over a software write in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_c_reg <= 2'b00;
        end else begin
            if (wr_ctrl_c) begin
                control_c_reg <= pwdata[1:0];
            end
            if (tmr_full && !up_auto && speed_sensor_select == 2'b00) begin
                control_c_reg[`MCDT_CC_OI] <= 1'b1;
            end else if (up_auto && speed_sensor_select == 2'b00) begin
                control_c_reg[`MCDT_CC_OI] <= 1'b1;
            end
        end
    end
    // Preloaded phase state applies at commutation or directly in direct access mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_a_reg <= 4'h0;
            irq_mask_reg <= 2'b00;
            speed_sensor_select <= 2'b00;
            delay_weight <= 8'h00;
            phase_pre_r <= 8'h00;
            phase_state_reg <= 8'h00;
        end else begin
            if (wr_ctrl_a) begin
                control_a_reg <= pwdata[3:0];
            end
            if (wr_irqmsk) begin
                irq_mask_reg <= pwdata[1:0];
            end
            if (wr_sensor) begin
                speed_sensor_select <= pwdata[1:0];
            end
            if (wr_weight) begin
                delay_weight <= pwdata[7:0];
            end
            if (wr_phase) begin
                phase_pre_r <= pwdata[7:0];
            end
            if (wr_phase && control_a_reg[`MCDT_CA_DAC]) begin
                phase_state_reg <= pwdata[7:0];
            end else if (comm_ev && !control_a_reg[`MCDT_CA_DAC]) begin
                phase_state_reg <= phase_pre_r;
            end
        end
    end
    // Read data is decoded in the setup cycle so it stands together with pready
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case (paddr)
            `MCDT_A_CTRL_A: rd_mux = {28'h0000000, control_a_reg};
            `MCDT_A_CTRL_C: rd_mux = {30'h00000000, control_c_reg};
            `MCDT_A_PRESC: rd_mux = {28'h0000000, prescaler_reg};
            `MCDT_A_IRQST: rd_mux = {29'h00000000, irq_status_reg};
            `MCDT_A_IRQMSK: rd_mux = {30'h00000000, irq_mask_reg};
            `MCDT_A_SENSOR: rd_mux = {30'h00000000, speed_sensor_select};
            `MCDT_A_TIMER: rd_mux = {24'h000000, step_timer};
            `MCDT_A_COMP: rd_mux = {24'h000000, commutation_compare};
            `MCDT_A_ZLAT: rd_mux = {24'h000000, zero_cross_latest};
            `MCDT_A_ZPRV: rd_mux = {24'h000000, zero_cross_prev};
            `MCDT_A_DEMAG: rd_mux = {24'h000000, demag_capture_reg};
            `MCDT_A_WEIGHT: rd_mux = {24'h000000, delay_weight};
            `MCDT_A_PHASE: rd_mux = {24'h000000, phase_state_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & addr_bad;
            if (rd) begin
                prdata <= rd_mux;
            end
        end
    end
    wire irq_comm = irq_status_reg[`MCDT_IS_CI] & irq_mask_reg[`MCDT_IM_CIM];
    wire irq_ratio = (|irq_status_reg[`MCDT_IS_RMI:`MCDT_IS_RPI]) & irq_mask_reg[`MCDT_IM_RIM] & auto_mode;
    // Motor side outputs are registered apart from the bus answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            commutation_pulse <= 1'b0;
            irq_req <= 1'b0;
            phase_state_out <= 8'h00;
            six_step_ok <= 1'b1;
        end else begin
            commutation_pulse <= comm_ev;
            irq_req <= irq_comm | irq_ratio;
            phase_state_out <= phase_state_reg;
            six_step_ok <= (speed_sensor_select == 2'b00);
        end
    end
endmodule

// [src/mcdt_defs.vh]
`ifndef MCDT_DEFS_VH
`define MCDT_DEFS_VH
`define MCDT_A_CTRL_A 8'h00
`define MCDT_A_CTRL_C 8'h04
`define MCDT_A_PRESC 8'h08
`define MCDT_A_IRQST 8'h0c
`define MCDT_A_IRQMSK 8'h10
`define MCDT_A_SENSOR 8'h14
`define MCDT_A_TIMER 8'h18
`define MCDT_A_COMP 8'h1c
`define MCDT_A_ZLAT 8'h20
`define MCDT_A_ZPRV 8'h24
`define MCDT_A_DEMAG 8'h28
`define MCDT_A_WEIGHT 8'h2c
`define MCDT_A_PHASE 8'h30
`define MCDT_CA_CKE 0
`define MCDT_CA_SWA 1
`define MCDT_CA_DCB 2
`define MCDT_CA_DAC 3
`define MCDT_CC_SC 0
`define MCDT_CC_OI 1
`define MCDT_IS_CI 0
`define MCDT_IS_RPI 1
`define MCDT_IS_RMI 2
`define MCDT_IM_CIM 0
`define MCDT_IM_RIM 1
`define MCDT_T_HALF 8'h80
`define MCDT_T_LOW 8'h55
`define MCDT_PRE_MAX 4'hf
`define MCDT_PRE_RST 4'h0
`endif

// [verif/mcdt_checker.sv]
`timescale 1ns/10ps
`include "mcdt_defs.vh"
module mcdt_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire zero_cross_in,
    input wire demag_in,
    input wire commutation_pulse,
    input wire irq_req,
    input wire [7:0] phase_state_out,
    input wire six_step_ok
);
    wire wr = psel && penable && pwrite;
    wire ph_wr = wr && paddr == `MCDT_A_PHASE;
    reg [1:0] mask_r;
    reg [1:0] sel_r;
    reg swa_r;
    reg armed_r;
    wire mask_any = |mask_r;
    wire sel_zero = sel_r == 2'b00;
    // Mirrors of software writes; only a compare write may arm a switched commutation
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 2'b00;
            sel_r <= 2'b00;
            swa_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            if (wr && paddr == `MCDT_A_IRQMSK) mask_r <= pwdata[1:0];
            if (wr && paddr == `MCDT_A_SENSOR) sel_r <= pwdata[1:0];
            if (wr && paddr == `MCDT_A_CTRL_A) swa_r <= pwdata[`MCDT_CA_SWA];
            if (commutation_pulse) armed_r <= 1'b0;
            if (wr && paddr == `MCDT_A_COMP) armed_r <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    rdy_after_setup_a: assert property (psel && !penable |=> pready && psel && penable)
        else $error("ready missing after setup");
    rdy_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    bad_addr_err_a: assert property (psel && !penable && (paddr > 8'h30 || paddr[1:0] != 2'b00) |=> pslverr)
        else $error("bad address not flagged");
    good_addr_ok_a: assert property (pready && paddr <= 8'h30 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("good address flagged");
    pulse_single_a: assert property (commutation_pulse |=> !commutation_pulse)
        else $error("commutation pulse too long");
    comm_needs_arm_a: assert property (commutation_pulse && !swa_r |-> armed_r)
        else $error("commutation without compare write");
    six_step_sel_a: assert property ($stable(sel_zero) [*3] |-> six_step_ok == sel_zero)
        else $error("six step flag wrong");
    phase_apply_a: assert property ($changed(phase_state_out) |-> commutation_pulse || $past(commutation_pulse)
        || $past(ph_wr) || $past(ph_wr, 2)) else $error("phase changed without cause");
    irq_gated_a: assert property (irq_req |-> mask_any || $past(mask_any) || $past(mask_any, 2))
        else $error("interrupt while masked");
    irq_on_comm_a: assert property (commutation_pulse && mask_r[0] |-> ##[0:2] irq_req)
        else $error("no interrupt after commutation");
    cover property (commutation_pulse);
    cover property (irq_req);
    cover property (pslverr);
    cover property (!six_step_ok);
endmodule

// [verif/mcdt_sensor_model.sv]
`timescale 1ns/10ps
module mcdt_sensor_model (
    input wire pclk,
    input wire zc_go,
    input wire dm_go,
    output reg zero_cross_in,
    output reg demag_in
);
    initial zero_cross_in = 1'b0;
    initial demag_in = 1'b0;
    // Levels last four cycles so the two-flop synchroniser cannot miss them
    always @(posedge pclk) if (zc_go) begin
        zero_cross_in <= 1'b1;
        repeat (4) @(posedge pclk);
        zero_cross_in <= 1'b0;
    end
    always @(posedge pclk) if (dm_go) begin
        demag_in <= 1'b1;
        repeat (4) @(posedge pclk);
        demag_in <= 1'b0;
    end
endmodule

// [verif/tb_motor_commutation_delay_timer.sv]
`timescale 1ns/10ps
`include "mcdt_defs.vh"
module tb_motor_commutation_delay_timer;
    reg pclk, presetn, psel, penable, pwrite, zc_go, dm_go;
    reg [7:0] paddr;
    reg [31:0] pwdata;
    wire [31:0] prdata;
    wire pready, pslverr, zero_cross_in, demag_in, commutation_pulse, irq_req, six_step_ok;
    wire [7:0] phase_state_out;
    integer fails, n_compared, k, n;
    logic [31:0] rdat, t0;
    logic err, seen;
    int m [0:15];
    int msk [0:15] = '{32'hf, 32'h3, 32'hf, 32'h7, 32'h3, 32'h3, 0, 32'hff, 32'hff, 0, 32'hff, 32'hff, 0, 0, 0, 0};
    mcdt_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .zero_cross_in(zero_cross_in), .demag_in(demag_in), .commutation_pulse(commutation_pulse),
        .irq_req(irq_req), .phase_state_out(phase_state_out), .six_step_ok(six_step_ok));
    mcdt_sensor_model i_sns (.pclk(pclk), .zc_go(zc_go), .dm_go(dm_go), .zero_cross_in(zero_cross_in),
        .demag_in(demag_in));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared = n_compared + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        m[a[5:2]] = d & msk[a[5:2]];
    endtask
    task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
        chk("slave error", 1'b0, err);
    endtask
    // Counts cycles to the next commutation, bounded so a silent design cannot hang the run
    task wait_comm(input int lim);
        seen = 1'b0;
        for (n = 0; n < lim && !seen; n++) begin
            @(negedge pclk);
            seen = commutation_pulse === 1'b1;
        end
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #400000;
        fails = fails + 1;
        summarize();
    end
    initial begin
        {presetn, psel, penable, pwrite, zc_go, dm_go, paddr, pwdata} = 0;
        fails = 0;
        n_compared = 0;
        k = $urandom(47146);
        for (k = 0; k < 16; k++) m[k] = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 13; k++) rd("reset value", k * 4, 0);
        for (k = 0; k < 3; k++) begin
            apb(1'b0, 8'h34 + k * 5, 32'h0);
            chk("unmapped error", 1'b1, err);
        end
        chk("six step", 1'b1, six_step_ok);
        wr(`MCDT_A_WEIGHT, $urandom);
        rd("weight", `MCDT_A_WEIGHT, m[11]);
        wr(`MCDT_A_DEMAG, $urandom);
        rd("demag", `MCDT_A_DEMAG, m[10]);
        wr(`MCDT_A_SENSOR, 1);
        repeat (4) @(posedge pclk);
        chk("six step", 1'b0, six_step_ok);
        wr(`MCDT_A_SENSOR, 0);
        wr(`MCDT_A_IRQMSK, 1);
        wr(`MCDT_A_PHASE, 8'h5a);
        rd("phase before", `MCDT_A_PHASE, 0);
        k = $urandom_range(60, 20);
        wr(`MCDT_A_COMP, k);
        rd("compare", `MCDT_A_COMP, m[7]);
        wr(`MCDT_A_CTRL_A, 1);
        wait_comm(200);
        chk("commutation", 1'b1, seen);
        apb(1'b0, `MCDT_A_TIMER, 32'h0);
        chk("timer restarted", 1'b1, rdat < 8);
        chk("phase applied", 8'h5a, phase_state_out);
        chk("irq", 1'b1, irq_req);
        rd("status", `MCDT_A_IRQST, 1);
        wr(`MCDT_A_IRQST, 0);
        repeat (3) @(posedge pclk);
        chk("irq", 1'b0, irq_req);
        wait_comm(300);
        chk("unarmed", 1'b0, seen);
        rd("overflow", `MCDT_A_CTRL_C, 2);
        wr(`MCDT_A_IRQST, 6);
        rd("both ratio", `MCDT_A_IRQST, 0);
        wr(`MCDT_A_IRQST, 2);
        wr(`MCDT_A_IRQST, 6);
        rd("both ratio", `MCDT_A_IRQST, 2);
        wr(`MCDT_A_PRESC, 5);
        rd("prescaler locked", `MCDT_A_PRESC, 0);
        wr(`MCDT_A_COMP, k);
        wait_comm(300);
        chk("commutation", 1'b1, seen);
        rd("prescaler up", `MCDT_A_PRESC, 1);
        rd("ratio cleared", `MCDT_A_IRQST, 1);
        rd("demag halved", `MCDT_A_DEMAG, m[10] >> 1);
        apb(1'b0, `MCDT_A_TIMER, 32'h0);
        t0 = rdat;
        repeat (64) @(posedge pclk);
        apb(1'b0, `MCDT_A_TIMER, 32'h0);
        chk("tick rate", 1'b1, rdat - t0 >= 32 && rdat - t0 <= 35);
        wr(`MCDT_A_CTRL_A, 0);
        apb(1'b0, `MCDT_A_TIMER, 32'h0);
        t0 = rdat;
        zc_go <= 1'b1;
        dm_go <= 1'b1;
        @(posedge pclk);
        zc_go <= 1'b0;
        dm_go <= 1'b0;
        repeat (12) @(posedge pclk);
        rd("timer held", `MCDT_A_TIMER, t0);
        wr(`MCDT_A_PRESC, 3);
        rd("prescaler", `MCDT_A_PRESC, 3);
        wr(`MCDT_A_CTRL_A, 3);
        repeat (2100) @(posedge pclk);
        rd("auto prescaler up", `MCDT_A_PRESC, 4);
        rd("auto ratio flag", `MCDT_A_IRQST, 3);
        summarize();
    end
endmodule
bind mcdt_core mcdt_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zero_cross_in(zero_cross_in), .demag_in(demag_in), .commutation_pulse(commutation_pulse),
    .irq_req(irq_req), .phase_state_out(phase_state_out), .six_step_ok(six_step_ok));
